// [logic/swdt_top.sv]
// Watchdog timer of a processor supervisor: watches the kick pin, drives
// the reset outputs, weakly drives the kick pin when it is left floating.
// Assumes one 50 MHz clock and a bench that resolves the weak kick driver
// and the open-drain reset line from the enables.
//
// What this block does
// - No kick within timeout asserts reset
// - Kick edge or reset clears timer
// - Pulses of 50 ns are still detected
// - Timer held zero while reset asserted
// - Counting resumes right after reset release
// - Weak drive low 7/8, high last 1/8
// - Floating pin self-kicks, no timeout occurs
// - Open-drain reset line shared, wired low
// - Reset held at least 140 ms
// - Manual reset input clears timer too
`timescale 1ns/10ps
`default_nettype none
module swdt_top
  import swdt_pkg::*;
#(
  parameter int unsigned WD_CYCLES = swdt_pkg::WD_CYC,
  parameter int unsigned HOLD_CYCLES = swdt_pkg::HOLD_CYC
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Kick pin
  input wire logic watchdog_kick_input,
  output swdt_pkg::swdt_pin_t kick_pin,
  // Manual reset
  input wire logic manual_reset_input_n,
  // Reset outputs
  output swdt_pkg::swdt_rst_t rst_out
);
  import swdt_pkg::*;

  // ==========================================================
  // State
  localparam int unsigned DRV_HIGH = WD_CYCLES - WD_CYCLES / 8;

  typedef struct packed {
    logic [CNT_W-1:0] wd_cnt;
    logic [CNT_W-1:0] hold_cnt;
    logic rst_act;
    swdt_pin_t pin;
    swdt_rst_t rst;
  } swdt_state_t;

  swdt_state_t st_ff;
  swdt_state_t nxt_st;
  logic kick_lvl;
  logic kick_edge;
  logic mr_lvl;

  // ==========================================================
  // Input synchronisers
  swdt_sync u_kick_sync
  (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .pin_in(watchdog_kick_input),
    .lvl(kick_lvl),
    .chg(kick_edge)
  );

  // Clears to low, so a power-up release always starts with a full hold
  swdt_sync u_mr_sync
  (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .pin_in(manual_reset_input_n),
    .lvl(mr_lvl),
    .chg()
  );

  // ==========================================================
  // Next state
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.pin.oe = 1'h1;
    if (!mr_lvl)
    begin
      // Manual reset keeps reset on and restarts the hold time
      nxt_st.rst_act = 1'h1;
      nxt_st.hold_cnt = '0;
      nxt_st.wd_cnt = '0;
    end
    else if (st_ff.rst_act)
    begin
      nxt_st.wd_cnt = '0;
      if (st_ff.hold_cnt >= CNT_W'(HOLD_CYCLES - 1))
      begin
        nxt_st.rst_act = 1'h0;
        nxt_st.hold_cnt = '0;
      end
      else
        nxt_st.hold_cnt = st_ff.hold_cnt + CNT_W'(1);
    end
    else if (kick_edge)
      nxt_st.wd_cnt = '0;
    else if (st_ff.wd_cnt >= CNT_W'(WD_CYCLES - 1))
    begin
      nxt_st.rst_act = 1'h1;
      nxt_st.hold_cnt = '0;
      nxt_st.wd_cnt = '0;
    end
    else
      nxt_st.wd_cnt = st_ff.wd_cnt + CNT_W'(1);
    // Self-kick on a floating pin: high edge near 7/8, low once cleared
    nxt_st.pin.drv = (nxt_st.wd_cnt >= CNT_W'(DRV_HIGH));
    nxt_st.rst.rst_h = nxt_st.rst_act;
    nxt_st.rst.rst_n = ~nxt_st.rst_act;
    nxt_st.rst.od_oe = nxt_st.rst_act;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      // Power-up behaves like any reset: held for the full hold time
      st_ff.wd_cnt <= '0;
      st_ff.hold_cnt <= '0;
      st_ff.rst_act <= RST_ACT_INIT;
      st_ff.pin.drv <= 1'h0;
      st_ff.pin.oe <= KICK_OE_INIT;
      st_ff.rst.rst_h <= RST_ACT_INIT;
      st_ff.rst.rst_n <= ~RST_ACT_INIT;
      st_ff.rst.od_oe <= RST_ACT_INIT;
    end
    else
      st_ff <= nxt_st;
  end

  assign kick_pin = st_ff.pin;
  assign rst_out = st_ff.rst;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  a_timeout_fires: assert property (
    (!st_ff.rst_act && mr_lvl && !kick_edge && st_ff.wd_cnt == CNT_W'(WD_CYCLES - 1))
    |=> st_ff.rst_act && rst_out.rst_h)
    else $error("watchdog expiry did not assert reset");

  a_edge_clears: assert property (
    (!st_ff.rst_act && mr_lvl && kick_edge) |=> st_ff.wd_cnt == '0)
    else $error("kick edge did not clear timer");

  // A level that is held across one sampling edge must reach the edge detector
  a_pulse_seen: assert property (
    $changed(watchdog_kick_input) |-> ##2 kick_edge)
    else $error("short kick pulse lost in synchroniser");

  a_hold_zero: assert property (
    (st_ff.rst_act && $past(st_ff.rst_act)) |-> st_ff.wd_cnt == '0)
    else $error("timer advanced during reset");

  a_count_start: assert property (
    ($fell(st_ff.rst_act) && mr_lvl && !kick_edge) |=> st_ff.wd_cnt == CNT_W'(1))
    else $error("timer did not start after reset release");

  a_drive_phase: assert property (
    kick_pin.drv == (st_ff.wd_cnt >= CNT_W'(DRV_HIGH)))
    else $error("weak kick drive in wrong phase");

  a_hold_len: assert property (
    (st_ff.rst_act && mr_lvl && st_ff.hold_cnt < CNT_W'(HOLD_CYCLES - 1))
    |=> st_ff.rst_act)
    else $error("reset released before hold time");

  a_mr_clears: assert property (
    !mr_lvl |=> st_ff.wd_cnt == '0 && rst_out.rst_h && !rst_out.rst_n)
    else $error("manual reset did not clear timer");

  a_polarity: assert property (
    rst_out.rst_h == !rst_out.rst_n && rst_out.od_oe == rst_out.rst_h)
    else $error("reset outputs disagree");

  a_edge_once: assert property (
    $changed(kick_lvl) |-> kick_edge ##1 !kick_edge || $changed(kick_lvl))
    else $error("level change without single edge");

  // Antecedents of the next three assertions exclude manual reset, which overrides every other path
  a_no_early_fire: assert property (
    (!st_ff.rst_act && mr_lvl && st_ff.wd_cnt < CNT_W'(WD_CYCLES - 1)) |=> !st_ff.rst_act)
    else $error("reset asserted before watchdog expiry");

  a_count_step: assert property (
    (!st_ff.rst_act && mr_lvl && !kick_edge && st_ff.wd_cnt < CNT_W'(WD_CYCLES - 1))
    |=> st_ff.wd_cnt == $past(st_ff.wd_cnt) + CNT_W'(1))
    else $error("timer did not advance by one");

  a_hold_release: assert property (
    (st_ff.rst_act && mr_lvl && st_ff.hold_cnt >= CNT_W'(HOLD_CYCLES - 1))
    |=> !st_ff.rst_act && rst_out.rst_n)
    else $error("reset not released after hold time");

  a_hold_bound: assert property (
    st_ff.rst_act |-> st_ff.hold_cnt < CNT_W'(HOLD_CYCLES))
    else $error("hold counter out of range");

  a_timer_bound: assert property (
    st_ff.wd_cnt < CNT_W'(WD_CYCLES))
    else $error("watchdog counter out of range");

  a_weak_drive_on: assert property (
    $past(nrst) |-> kick_pin.oe)
    else $error("weak kick driver not enabled");

  c_timeout: cover property (!st_ff.rst_act ##1 st_ff.rst_act);
  c_release: cover property ($fell(st_ff.rst_act));
  c_kick: cover property (!st_ff.rst_act && kick_edge);
  c_self_kick: cover property ($rose(kick_pin.drv) ##[1:8] kick_edge);
  c_manual: cover property ($rose(mr_lvl));
endmodule
`default_nettype wire

// [logic/swdt_pkg.sv]
// Shared constants and carrier types of the supervisor watchdog timer.
// Assumes a single 50 MHz system clock; times are converted to cycles here.
package swdt_pkg;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned CLK_PER_KHZ = CLK_HZ / 1000;
  localparam int unsigned WD_TIMEOUT_MS = 1600;
  localparam int unsigned HOLD_MS = 140;
  localparam int unsigned KICK_MIN_NS = 50;
  localparam int unsigned CLK_PERIOD_NS = 1000000000 / CLK_HZ;
  // Longest time rounds down
  localparam int unsigned WD_CYC = WD_TIMEOUT_MS * CLK_PER_KHZ;
  // Least time rounds up
  localparam int unsigned HOLD_CYC = HOLD_MS * CLK_PER_KHZ;
  localparam int unsigned KICK_MIN_CYC = (KICK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 32;

  // ==========================================================
  // Reset values
  localparam logic RST_ACT_INIT = 1'h1;
  localparam logic KICK_OE_INIT = 1'h0;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic rst_h;
    logic rst_n;
    logic od_oe;
  } swdt_rst_t;

  typedef struct packed {
    logic drv;
    logic oe;
  } swdt_pin_t;

endpackage

// [logic/swdt_sync.sv]
// Two-stage synchroniser with a change detector behind it.
// Assumes the input is asynchronous to sys_clk.
`timescale 1ns/10ps
`default_nettype none
module swdt_sync
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Pin side
  input wire logic pin_in,
  // Synchronised side
  output logic lvl,
  output logic chg
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } swdt_sync_st_t;

  swdt_sync_st_t st_ff;
  swdt_sync_st_t nxt_st;

  always_comb
  begin
    nxt_st.s1 = pin_in;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  // First stage is read only by the second; change seen from stages 2 and 3
  assign lvl = st_ff.s2;
  assign chg = st_ff.s2 ^ st_ff.s3;
endmodule
`default_nettype wire

// [tb/swdt_host.sv]
// Host model on the kick pin: drives it or leaves it floating.
// Assumes the weak driver of the block loses against the host.
`timescale 1ns/10ps
`default_nettype none
module swdt_host
(
  // Clock
  input wire logic sys_clk,
  // Host side
  input wire logic host_en,
  input wire logic host_val,
  // Pin
  input wire swdt_pkg::swdt_pin_t kick_pin,
  output logic pin
);
  import swdt_pkg::*;
  logic last_ff;
  // ==========================================================
  // Resolution
  // Undriven pin shows no stale level, so it flips each cycle
  always_comb pin = host_en ? host_val : (kick_pin.oe ? kick_pin.drv : ~last_ff);
  always_ff @(posedge sys_clk) last_ff <= pin;
endmodule
`default_nettype wire

// [tb/swdt_top_tb.sv]
// Self-checking bench of the watchdog top with a host model.
// Assumes shortened counts: 64-cycle watchdog, 10-cycle hold.
`timescale 1ns/10ps
`default_nettype none
module swdt_top_tb;
  import swdt_pkg::*;
  localparam int WD = 64;
  localparam int HOLD = 10;
  logic sys_clk = 1'h0;
  logic nrst = 1'h0;
  logic host_en = 1'h1;
  logic host_val = 1'h0;
  logic mr_n = 1'h1;
  logic kick;
  swdt_pin_t kick_pin;
  swdt_rst_t rst_out;
  int failures = 0;
  int n_tests = 0;
  int n;
  always #10 sys_clk = ~sys_clk;
  swdt_host swdt_host_i (.sys_clk(sys_clk), .host_en(host_en), .host_val(host_val),
    .kick_pin(kick_pin), .pin(kick));
  swdt_top #(.WD_CYCLES(WD), .HOLD_CYCLES(HOLD)) swdt_top_i (.sys_clk(sys_clk), .nrst(nrst),
    .watchdog_kick_input(kick), .kick_pin(kick_pin), .manual_reset_input_n(mr_n),
    .rst_out(rst_out));
  // ==========================================================
  // Helpers
  task automatic cyc(int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Cycles until reset output reaches level v, bounded
  task automatic wait_rst(logic v, int lim);
    n = 0;
    while (rst_out.rst_h !== v && n < lim)
    begin
      cyc(1);
      n++;
    end
    if (rst_out.rst_h !== v)
    begin
      failures++;
      final_report();
    end
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_power_up();
    chk(rst_out.rst_h, 1'h1);
    chk(rst_out.od_oe, 1'h1);
    wait_rst(1'h0, 60);
    chk(n >= HOLD, 1'h1);
    chk(rst_out.rst_n, 1'h1);
  endtask
  // Steady pin times out; an edge inside the hold is ignored
  task automatic t_timeout();
    repeat (2)
    begin
      wait_rst(1'h1, 200);
      chk(n, WD);
      chk({rst_out.rst_n, rst_out.od_oe}, 2'h1);
      cyc(3);
      host_val = ~host_val;
      wait_rst(1'h0, 100);
      chk(n, HOLD - 3);
    end
  endtask
  task automatic t_kicks();
    repeat (5)
    begin
      cyc(40);
      host_val = 1'h1;
      #50;
      host_val = 1'h0;
      chk(rst_out.rst_h, 1'h0);
      chk(kick_pin.drv, 1'h0);
    end
  endtask
  task automatic t_float();
    int hi;
    int seen;
    hi = 0;
    seen = 0;
    host_en = 1'h0;
    repeat (300)
    begin
      cyc(1);
      hi += int'(kick_pin.drv);
      seen |= int'(rst_out.rst_h);
    end
    chk(hi > 0 && hi < 300 / 8, 1'h1);
    chk(seen, 0);
  endtask
  task automatic t_manual();
    host_en = 1'h1;
    mr_n = 1'h0;
    cyc(4);
    chk(rst_out.rst_h, 1'h1);
    cyc(20);
    chk(rst_out.rst_h, 1'h1);
    mr_n = 1'h1;
    wait_rst(1'h0, 40);
    chk(n >= HOLD, 1'h1);
    wait_rst(1'h1, 200);
    chk(n, WD);
  endtask
  initial
  begin
    cyc(16);
    nrst = 1'h1;
    cyc(1);
    t_power_up();
    t_timeout();
    t_kicks();
    t_float();
    t_manual();
    final_report();
  end
endmodule
`default_nettype wire
